// [verilog/mes_defs.vh]
// Constants for the memory map decoder and operating environment selection.
// Assumes a 24-bit byte address from the CPU core bus and a 100 MHz clock.
`ifndef MES_DEFS_VH
`define MES_DEFS_VH

// Address space and field widths
`define MES_ADDR_W 24
`define MES_STRAP_W 3
`define MES_BLANK_W 2
`define MES_ENV_W 4
`define MES_ZONE_W 3

// Region bounds, inclusive
`define MES_PFLASH_LO 24'h000000
`define MES_PFLASH_HI 24'h03FFFF
`define MES_DFLASH_LO 24'h0E0000
`define MES_DFLASH_HI 24'h0E1FFF
`define MES_RAM_LO 24'h0EC000
`define MES_RAM_HI 24'h0EE7FF
`define MES_EXT1_LO 24'h400000
`define MES_EXT1_HI 24'h7FFFFF
`define MES_EXT2_LO 24'h800000
`define MES_EXT2_HI 24'hFEFFFF
`define MES_BIUP_LO 24'hFF0000
`define MES_BIUP_HI 24'hFFFAFF
`define MES_IOZ_LO 24'hFFFB00
`define MES_IOZ_HI 24'hFFFBFF
`define MES_PERI_LO 24'hFFFC00
`define MES_PERI_HI 24'hFFFFFF

// Largest external memory space, in bytes (12 Mbytes)
`define MES_EXT_LIMIT 24'hC00000

// Strap codes
`define MES_STRAP_IBOOT 3'h7
`define MES_STRAP_XBOOT 3'h3
`define MES_STRAP_ISP 3'h6
`define MES_STRAP_DEV 3'h0
`define MES_STRAP_RST 3'h7

// Environment codes, one-hot
`define MES_ENV_IBOOT 4'h1
`define MES_ENV_XBOOT 4'h2
`define MES_ENV_DEV 4'h4
`define MES_ENV_ISP 4'h8

// Bus-interface zone tags
`define MES_ZONE_S0 3'h0
`define MES_ZONE_S1 3'h1
`define MES_ZONE_S2 3'h2
`define MES_ZONE_IO 3'h3
`define MES_ZONE_NONE 3'h7

// Cycles from reset release until the synchronised straps are trusted
`define MES_SETTLE_CYC 2'h2

`endif

// [verilog/mes_sync2.v]
// Two-stage synchroniser for a bundle of pin levels.
// Assumes the inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ns
module mes_sync2 #(
    parameter W = 3,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Level in and out
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage is read only by the second stage
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule // mes_sync2

// [verilog/mes_env_sel.v]
// Combinational choice of the operating environment from straps and blank flags.
// Assumes both inputs are already synchronous to the system clock.
`timescale 1ns/1ns
`include "mes_defs.vh"
module mes_env_sel (
    // Inputs
    input wire [`MES_STRAP_W-1:0] strap,
    input wire [`MES_BLANK_W-1:0] blank_flags,
    // One-hot environment
    output reg [`MES_ENV_W-1:0] env
);
    wire flash_blank;

    // Program flash counts as unprogrammed only when every blank flag is set
    assign flash_blank = &blank_flags;

    // Straps with no defined meaning fall back to the pull-up behaviour
    always @* begin
        case (strap)
            `MES_STRAP_DEV: env = `MES_ENV_DEV;
            `MES_STRAP_ISP: env = `MES_ENV_ISP;
            `MES_STRAP_XBOOT: env = flash_blank ? `MES_ENV_ISP : `MES_ENV_XBOOT;
            `MES_STRAP_IBOOT: env = flash_blank ? `MES_ENV_ISP : `MES_ENV_IBOOT;
            default: env = flash_blank ? `MES_ENV_ISP : `MES_ENV_IBOOT;
        endcase
    end
endmodule // mes_env_sel

// [verilog/mes_top.v]
// Memory map decoder with operating environment selection.
// Assumes strap pins are asynchronous, blank flags come from on-chip flash logic on
// the same clock, and the CPU presents one request per cycle with a stable address.
`timescale 1ns/1ns
`include "mes_defs.vh"

// Summary of operation
// - Decode one flat 16-Mbyte address space
// - Tag every decoded region with its zone; RAM and both peripheral ranges get no zone
// - 000000h-03FFFFh is program flash, zone 0
// - 0E0000h-0E1FFFh is data flash, zone 0
// - Zone 0 goes external in development environment
// - 400000h-7FFFFFh is external zone 1
// - 800000h-FEFFFFh is external zone 2
// - FFFC00h-FFFFFFh is peripherals, no zone
// - Environment sets external support and vector
// - External memory space limited to 12 Mbytes
// - Environment from straps plus flash blank flags
// - Floating straps read ones via pull-ups
// - Strap 111 internal boot, blank gives IN_SYSTEM_PROGRAMMING_ENVIRONMENT
// - Strap 011 external boot, blank gives IN_SYSTEM_PROGRAMMING_ENVIRONMENT
// - Strap 110 always in-system programming
// - Strap 000 development, flash disabled, external
module mes_top (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Strap pins and flash blank flags
    input wire [`MES_STRAP_W-1:0] environment_strap_pins,
    input wire [`MES_BLANK_W-1:0] flash_blank_flags,
    // CPU core bus request
    input wire cpu_req,
    input wire cpu_wr,
    input wire [`MES_ADDR_W-1:0] cpu_addr,
    // Environment state
    output reg [`MES_ENV_W-1:0] env_q,
    output reg env_valid_q,
    output reg ext_mem_enable_q,
    output reg reset_vector_isp_q,
    output reg flash_disable_q,
    // Decode result, one cycle after the request
    output reg dec_valid_q,
    output reg dec_wr_q,
    output reg [`MES_ZONE_W-1:0] dec_zone_q,
    output reg sel_prog_flash_q,
    output reg sel_data_flash_q,
    output reg sel_ram_q,
    output reg sel_ext_q,
    output reg sel_bus_ctl_periph_q,
    output reg sel_io_zone_q,
    output reg sel_periph_q,
    output reg dec_reserved_q,
    output reg dec_refused_q,
    output reg [`MES_ADDR_W-1:0] ext_addr_q
);
    // Start-up sequencer states
    localparam [2:0] ST_SETTLE = 3'h1;
    localparam [2:0] ST_CAPTURE = 3'h2;
    localparam [2:0] ST_RUN = 3'h4;

    // Region indices for the decode vector
    localparam RG_PFLASH = 0;
    localparam RG_DFLASH = 1;
    localparam RG_RAM = 2;
    localparam RG_EXT1 = 3;
    localparam RG_EXT2 = 4;
    localparam RG_BIUP = 5;
    localparam RG_IOZ = 6;
    localparam RG_PERI = 7;
    localparam NRG = 8;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [1:0] settle_q;
    wire [`MES_STRAP_W-1:0] strap_sync;
    wire [`MES_ENV_W-1:0] env_pick;
    wire [NRG-1:0] hit;
    wire [`MES_ADDR_W-1:0] lo_tab [0:NRG-1];
    wire [`MES_ADDR_W-1:0] hi_tab [0:NRG-1];
    wire is_dev;
    wire zone0_hit;
    wire ext_route;
    wire ext_ok;
    wire [`MES_ADDR_W-1:0] ext_off;
    reg [`MES_ZONE_W-1:0] zone_d;
    // Accepted request and next values of the decode registers
    wire take;
    reg dec_valid_d;
    reg dec_wr_d;
    reg sel_prog_flash_d;
    reg sel_data_flash_d;
    reg sel_ram_d;
    reg sel_ext_d;
    reg sel_bus_ctl_periph_d;
    reg sel_io_zone_d;
    reg sel_periph_d;
    reg dec_reserved_d;
    reg dec_refused_d;
    reg [`MES_ADDR_W-1:0] ext_addr_d;

    // True when addr lies inside the inclusive range lo..hi
    function in_range;
        input [`MES_ADDR_W-1:0] addr;
        input [`MES_ADDR_W-1:0] lo;
        input [`MES_ADDR_W-1:0] hi;
        begin
            in_range = (addr >= lo) && (addr <= hi);
        end
    endfunction

    // External memory is supported only where the environment brings out the bus
    function ext_supported;
        input [`MES_ENV_W-1:0] env;
        begin
            ext_supported = (env == `MES_ENV_XBOOT) || (env == `MES_ENV_DEV);
        end
    endfunction

    // Reset vector goes to the programming code space only in that environment
    function vector_to_isp;
        input [`MES_ENV_W-1:0] env;
        begin
            vector_to_isp = (env == `MES_ENV_ISP);
        end
    endfunction

    // Development environment turns the on-chip flash off
    function flash_off;
        input [`MES_ENV_W-1:0] env;
        begin
            flash_off = (env == `MES_ENV_DEV);
        end
    endfunction

    // Straps reset to all ones, as floating pins pulled up would read
    mes_sync2 #(
        .W(`MES_STRAP_W),
        .RST_VAL(`MES_STRAP_RST)
    ) u_strap_sync (
        .clock(clock),
        .rst_n(rst_n),
        .din(environment_strap_pins),
        .dout(strap_sync)
    );

    // Environment from synchronised straps and blank flags
    mes_env_sel u_env_sel (
        .strap(strap_sync),
        .blank_flags(flash_blank_flags),
        .env(env_pick)
    );

    // Region table
    assign lo_tab[RG_PFLASH] = `MES_PFLASH_LO;
    assign hi_tab[RG_PFLASH] = `MES_PFLASH_HI;
    assign lo_tab[RG_DFLASH] = `MES_DFLASH_LO;
    assign hi_tab[RG_DFLASH] = `MES_DFLASH_HI;
    assign lo_tab[RG_RAM] = `MES_RAM_LO;
    assign hi_tab[RG_RAM] = `MES_RAM_HI;
    assign lo_tab[RG_EXT1] = `MES_EXT1_LO;
    assign hi_tab[RG_EXT1] = `MES_EXT1_HI;
    assign lo_tab[RG_EXT2] = `MES_EXT2_LO;
    assign hi_tab[RG_EXT2] = `MES_EXT2_HI;
    assign lo_tab[RG_BIUP] = `MES_BIUP_LO;
    assign hi_tab[RG_BIUP] = `MES_BIUP_HI;
    assign lo_tab[RG_IOZ] = `MES_IOZ_LO;
    assign hi_tab[RG_IOZ] = `MES_IOZ_HI;
    assign lo_tab[RG_PERI] = `MES_PERI_LO;
    assign hi_tab[RG_PERI] = `MES_PERI_HI;

    // One comparator pair per region over the full 24-bit space
    genvar gi;
    generate
        for (gi = 0; gi < NRG; gi = gi + 1) begin : g_hit
            assign hit[gi] = in_range(cpu_addr, lo_tab[gi], hi_tab[gi]);
        end
    endgenerate

    // Start-up sequencer: wait for the synchroniser, capture once, then run
    // Three settle edges let both synchroniser stages fill before capture
    always @* begin
        case (state_q)
            ST_SETTLE: state_d = (settle_q == `MES_SETTLE_CYC) ? ST_CAPTURE : ST_SETTLE;
            ST_CAPTURE: state_d = ST_RUN;
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_SETTLE;
        endcase
    end

    // Sequencer state and settle count
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SETTLE;
            settle_q <= 2'h0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_SETTLE) begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    // Environment capture happens exactly once per reset
    // Blank flags share this clock, so they are read without a synchroniser
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            env_q <= `MES_ENV_IBOOT;
            env_valid_q <= 1'b0;
            ext_mem_enable_q <= 1'b0;
            reset_vector_isp_q <= 1'b0;
            flash_disable_q <= 1'b0;
        end else if (state_q == ST_CAPTURE) begin
            env_q <= env_pick;
            env_valid_q <= 1'b1;
            ext_mem_enable_q <= ext_supported(env_pick);
            reset_vector_isp_q <= vector_to_isp(env_pick);
            flash_disable_q <= flash_off(env_pick);
        end
    end

    // Routing of zone 0 and external zones
    // The offset compare holds every external route under the size ceiling
    assign is_dev = flash_disable_q;
    assign zone0_hit = hit[RG_PFLASH] | hit[RG_DFLASH];
    assign ext_route = hit[RG_EXT1] | hit[RG_EXT2] | (zone0_hit & is_dev);
    assign ext_off = (hit[RG_EXT1] | hit[RG_EXT2]) ?
                     (cpu_addr - `MES_EXT1_LO) : cpu_addr;
    assign ext_ok = ext_mem_enable_q && (ext_off < `MES_EXT_LIMIT);

    // Zone tag for the decoded region
    always @* begin
        if (zone0_hit) begin
            zone_d = `MES_ZONE_S0;
        end else if (hit[RG_EXT1]) begin
            zone_d = `MES_ZONE_S1;
        end else if (hit[RG_EXT2]) begin
            zone_d = `MES_ZONE_S2;
        end else if (hit[RG_IOZ]) begin
            zone_d = `MES_ZONE_IO;
        end else begin
            zone_d = `MES_ZONE_NONE;
        end
    end

    // Requests before the environment is known are ignored
    assign take = cpu_req & env_valid_q;

    // Next decode result; at most one select per accepted request
    always @* begin
        dec_valid_d = take;
        dec_wr_d = take & cpu_wr;
        // Internal flash only serves zone 0 outside development
        sel_prog_flash_d = take & hit[RG_PFLASH] & ~is_dev;
        sel_data_flash_d = take & hit[RG_DFLASH] & ~is_dev;
        sel_ram_d = take & hit[RG_RAM];
        sel_ext_d = take & ext_route & ext_ok;
        sel_bus_ctl_periph_d = take & hit[RG_BIUP];
        sel_io_zone_d = take & hit[RG_IOZ];
        sel_periph_d = take & hit[RG_PERI];
        // Unlisted ranges select nothing and are flagged
        dec_reserved_d = take & ~(|hit);
        // External access in an environment without external memory
        dec_refused_d = take & ext_route & ~ext_ok;
        ext_addr_d = ext_route ? ext_off : 24'h000000;
    end

    // Registered decode, one cycle after the request
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid_q <= 1'b0;
            dec_wr_q <= 1'b0;
            dec_zone_q <= `MES_ZONE_NONE;
            sel_prog_flash_q <= 1'b0;
            sel_data_flash_q <= 1'b0;
            sel_ram_q <= 1'b0;
            sel_ext_q <= 1'b0;
            sel_bus_ctl_periph_q <= 1'b0;
            sel_io_zone_q <= 1'b0;
            sel_periph_q <= 1'b0;
            dec_reserved_q <= 1'b0;
            dec_refused_q <= 1'b0;
            ext_addr_q <= 24'h000000;
        end else begin
            dec_valid_q <= dec_valid_d;
            dec_wr_q <= dec_wr_d;
            dec_zone_q <= zone_d;
            sel_prog_flash_q <= sel_prog_flash_d;
            sel_data_flash_q <= sel_data_flash_d;
            sel_ram_q <= sel_ram_d;
            sel_ext_q <= sel_ext_d;
            sel_bus_ctl_periph_q <= sel_bus_ctl_periph_d;
            sel_io_zone_q <= sel_io_zone_d;
            sel_periph_q <= sel_periph_d;
            dec_reserved_q <= dec_reserved_d;
            dec_refused_q <= dec_refused_d;
            ext_addr_q <= ext_addr_d;
        end
    end
endmodule // mes_top

// [testbench/mes_cpu_model.sv]
// CPU core bus master model for the decoder.
// Assumes the bench calls its tasks; signals change only after a rising edge.
`timescale 1ns/1ns
module mes_cpu_model (
    // Clock
    input wire clock,
    // Request towards the decoder
    output reg cpu_req,
    output reg cpu_wr,
    output reg [23:0] cpu_addr
);
    // Bus idle at time zero
    initial begin
        cpu_req = 1'b0;
        cpu_wr = 1'b0;
        cpu_addr = 24'h000000;
    end
    // One request a cycle; reserved places only when the caller picks them
    task issue(input [23:0] a, input w);
        begin
            @(posedge clock);
            cpu_req <= 1'b1;
            cpu_wr <= w;
            cpu_addr <= a;
        end
    endtask
    // Released bus shows the inverse of its last value
    task idle;
        begin
            @(posedge clock);
            cpu_req <= 1'b0;
            cpu_wr <= ~cpu_wr;
            cpu_addr <= ~cpu_addr;
        end
    endtask
endmodule // mes_cpu_model

// [testbench/mes_checker.sv]
// Concurrent checks on the decoder ports.
// Assumes one clock domain and the reset of that domain.
`timescale 1ns/1ns
`include "mes_defs.vh"
module mes_checker (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Request
    input wire cpu_req,
    input wire [`MES_ADDR_W-1:0] cpu_addr,
    // Environment
    input wire [`MES_ENV_W-1:0] env_q,
    input wire env_valid_q,
    input wire ext_mem_enable_q,
    input wire reset_vector_isp_q,
    input wire flash_disable_q,
    // Decode result
    input wire dec_valid_q,
    input wire [`MES_ZONE_W-1:0] dec_zone_q,
    input wire sel_prog_flash_q,
    input wire sel_data_flash_q,
    input wire sel_ext_q,
    input wire sel_periph_q,
    input wire [`MES_ADDR_W-1:0] ext_addr_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Accepted request and region hits
    wire tk = cpu_req && env_valid_q;
    wire in_pf = cpu_addr <= `MES_PFLASH_HI;
    wire in_df = cpu_addr >= `MES_DFLASH_LO && cpu_addr <= `MES_DFLASH_HI;
    wire in_ex = cpu_addr >= `MES_EXT1_LO && cpu_addr <= `MES_EXT2_HI;
    // Release followed by settle and capture
    sequence s_release;
        $rose(rst_n);
    endsequence
    sequence s_capture;
        !env_valid_q ##[2:5] env_valid_q;
    endsequence
    a_dec_answer: assert property (tk |=> dec_valid_q) else $error("no decode answer");
    a_dec_quiet: assert property (!tk |=> !dec_valid_q) else $error("spurious decode");
    a_pflash_map: assert property (tk && in_pf && !flash_disable_q
        |=> sel_prog_flash_q && dec_zone_q == `MES_ZONE_S0) else $error("program flash miss");
    a_dflash_map: assert property (tk && in_df && !flash_disable_q
        |=> sel_data_flash_q && dec_zone_q == `MES_ZONE_S0) else $error("data flash miss");
    a_dev_zone_ext: assert property (tk && in_pf && flash_disable_q
        |=> sel_ext_q && !sel_prog_flash_q && ext_addr_q == $past(cpu_addr))
        else $error("zone 0 not external");
    a_ext_zone_map: assert property (tk && in_ex && ext_mem_enable_q
        |=> sel_ext_q && ext_addr_q == $past(cpu_addr) - `MES_EXT1_LO
        && dec_zone_q == ($past(cpu_addr[23]) ? `MES_ZONE_S2 : `MES_ZONE_S1))
        else $error("external zone miss");
    a_periph_map: assert property (tk && cpu_addr >= `MES_PERI_LO
        |=> sel_periph_q && dec_zone_q == `MES_ZONE_NONE) else $error("peripheral miss");
    a_env_held: assert property (env_valid_q && $past(env_valid_q) |-> $stable(env_q))
        else $error("environment changed");
    a_env_flags: assert property (env_valid_q |-> $onehot(env_q)
        && flash_disable_q == (env_q == `MES_ENV_DEV)
        && reset_vector_isp_q == (env_q == `MES_ENV_ISP)
        && ext_mem_enable_q == (env_q == `MES_ENV_XBOOT || env_q == `MES_ENV_DEV))
        else $error("environment flags wrong");
    a_env_capture: assert property (s_release |-> s_capture) else $error("no capture");
endmodule // mes_checker

// [testbench/memory_map_env_select_test.sv]
// Self-checking bench for the decoder and environment selection.
// Assumes the design files and the defines header are compiled before it.
`timescale 1ns/1ns
`include "mes_defs.vh"
module memory_map_env_select_test;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [2:0] strap_val = 3'h7;
    reg strap_en = 1'b1;
    reg [1:0] blank = 2'h0;
    tri1 [2:0] strap_w;
    wire cpu_req, cpu_wr, ext_en, vec_isp, fdis, dv, dw, res, rfs, env_valid_q;
    wire [23:0] cpu_addr, ext_addr;
    wire [3:0] env_q;
    wire [2:0] zone;
    wire [6:0] sel;
    integer errors = 0, total_checks = 0, seed = 36044, cyc = 0, i, k;
    reg [3:0] m_env;
    reg dec_on = 1'b0, p_v = 1'b0, p_w;
    reg [23:0] p_a, r;
    localparam [17:0] STRAPS = {3'h5, 3'h0, 3'h6, 3'h3, 3'h7, 3'h7};
    localparam [455:0] ADRS = {24'h000000, 24'h03FFFF, 24'h040000, 24'h0E0000,
        24'h0E1FFF, 24'h0E2000, 24'h0EC000, 24'h0EE7FF, 24'h3FFFFF, 24'h400000,
        24'h7FFFFF, 24'h800000, 24'hFEFFFF, 24'hFF0000, 24'hFFFAFF, 24'hFFFB00,
        24'hFFFBFF, 24'hFFFC00, 24'hFFFFFF};
    // Clock and floating straps pulled high
    always #5 clock = ~clock;
    assign strap_w = strap_en ? strap_val : 3'bzzz;
    mes_cpu_model i_cpu (.clock(clock), .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr));
    mes_top i_dut (.clock(clock), .rst_n(rst_n), .environment_strap_pins(strap_w),
        .flash_blank_flags(blank), .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
        .env_q(env_q), .env_valid_q(env_valid_q), .ext_mem_enable_q(ext_en),
        .reset_vector_isp_q(vec_isp), .flash_disable_q(fdis), .dec_valid_q(dv), .dec_wr_q(dw),
        .dec_zone_q(zone), .sel_prog_flash_q(sel[6]), .sel_data_flash_q(sel[5]),
        .sel_ram_q(sel[4]), .sel_ext_q(sel[3]), .sel_bus_ctl_periph_q(sel[2]),
        .sel_io_zone_q(sel[1]), .sel_periph_q(sel[0]), .dec_reserved_q(res),
        .dec_refused_q(rfs), .ext_addr_q(ext_addr));
    // Environment from straps and blank flags
    function [3:0] env_f(input [2:0] s, input [1:0] b);
        if (s == 3'h6) env_f = `MES_ENV_ISP;
        else if (s == 3'h0) env_f = `MES_ENV_DEV;
        else if (&b) env_f = `MES_ENV_ISP;
        else env_f = (s == 3'h3) ? `MES_ENV_XBOOT : `MES_ENV_IBOOT;
    endfunction
    // Decode result: valid, write, zone, selects, reserved, refused, offset
    function [37:0] dec_f(input [23:0] a, input w, input [3:0] e);
        reg [2:0] z;
        reg [8:0] s;
        reg [23:0] x;
        begin
            z = 3'h7;
            x = 24'h0;
            s = 9'h002;
            if (a <= 24'h03FFFF || (a >= 24'h0E0000 && a <= 24'h0E1FFF)) begin
                z = 3'h0;
                x = (e == `MES_ENV_DEV) ? a : 24'h0;
                s = (e == `MES_ENV_DEV) ? 9'h020 : (a <= 24'h03FFFF) ? 9'h100 : 9'h080;
            end else if (a >= 24'h0EC000 && a <= 24'h0EE7FF) s = 9'h040;
            else if (a >= 24'h400000 && a <= 24'hFEFFFF) begin
                z = a[23] ? 3'h2 : 3'h1;
                s = 9'h001;
                x = a - 24'h400000;
                if ((e == `MES_ENV_XBOOT || e == `MES_ENV_DEV) && x < 24'hC00000) begin
                    s = 9'h020;
                end
            end else if (a >= 24'hFF0000 && a <= 24'hFFFAFF) s = 9'h010;
            else if (a >= 24'hFFFB00 && a <= 24'hFFFBFF) begin
                z = 3'h3;
                s = 9'h008;
            end else if (a >= 24'hFFFC00) s = 9'h004;
            dec_f = {1'b1, w, z, s, x};
        end
    endfunction
    task chk(input [63:0] seen, input [63:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task summarize;
        begin
            $display("Checks %0d, mismatches %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    // Compare every decode cycle with the model; cut a hang short
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (dec_on && p_v) begin
            chk({dv, dw, zone, sel, res, rfs, ext_addr}, dec_f(p_a, p_w, m_env));
        end else if (dec_on) begin
            chk({dv, dw, sel, res, rfs}, 11'h0);
        end
        p_v = cpu_req;
        p_w = cpu_wr;
        p_a = cpu_addr;
        if (cyc > 5000) begin
            errors = errors + 1;
            summarize;
        end
    end
    // Reset with given straps, check the capture, then disturb the straps
    task boot(input [2:0] s, input en, input [1:0] b);
        begin
            dec_on = 1'b0;
            @(posedge clock);
            rst_n <= 1'b0;
            strap_val <= s;
            strap_en <= en;
            blank <= b;
            repeat (6) @(posedge clock);
            rst_n <= 1'b1;
            m_env = env_f(en ? s : 3'h7, b);
            repeat (5) @(posedge clock);
            #1;
            chk({env_valid_q, env_q, ext_en, vec_isp, fdis}, {1'b1, m_env,
                m_env == `MES_ENV_XBOOT || m_env == `MES_ENV_DEV, m_env == `MES_ENV_ISP,
                m_env == `MES_ENV_DEV});
            @(posedge clock);
            strap_val <= ~s;
            strap_en <= 1'b1;
            blank <= ~b;
            repeat (4) @(posedge clock);
            #1;
            chk(env_q, m_env);
            dec_on = 1'b1;
        end
    endtask
    initial begin
        for (i = 0; i < 12; i = i + 1) begin
            boot((i % 6) ? STRAPS[3 * (i % 6) +: 3] : 3'h0, (i % 6) != 0,
                (i >= 6) ? 2'h3 : i[1:0]);
            for (k = 0; k < 19; k = k + 1) i_cpu.issue(ADRS[24 * k +: 24], k[0]);
            for (k = 0; k < 20; k = k + 1) begin
                r = $random(seed);
                while (dec_f(r, 1'b0, m_env) & 38'h2000000) r = $random(seed);
                i_cpu.issue(r, $random(seed));
            end
            i_cpu.idle;
            repeat (3) @(posedge clock);
            $display("Boot %0d done", i);
        end
        summarize;
    end
endmodule // memory_map_env_select_test
// Checker beside the decoder top
bind mes_top mes_checker i_chk (.clock(clock), .rst_n(rst_n), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .env_q(env_q), .env_valid_q(env_valid_q),
    .ext_mem_enable_q(ext_mem_enable_q), .reset_vector_isp_q(reset_vector_isp_q),
    .flash_disable_q(flash_disable_q), .dec_valid_q(dec_valid_q), .dec_zone_q(dec_zone_q),
    .sel_prog_flash_q(sel_prog_flash_q), .sel_data_flash_q(sel_data_flash_q),
    .sel_ext_q(sel_ext_q), .sel_periph_q(sel_periph_q), .ext_addr_q(ext_addr_q));
